// file: src/charger_regs_pkg.sv
package charger_regs_pkg;
    localparam int          DATA_W                    = 8;
    localparam logic [7:0]  OFS_EVENT_SUMMARY         = 8'h22;
    localparam logic [7:0]  OFS_SYSTEM_EVENT_MASK     = 8'h26;
    localparam logic [7:0]  OFS_CHARGER_EVENT_FLAGS   = 8'hB0;
    localparam logic [7:0]  OFS_CHARGER_EVENT_MASK    = 8'hB1;
    localparam logic [7:0]  OFS_CHARGER_OKAY_STATUS   = 8'hB2;
    localparam logic [7:0]  OFS_CHARGER_DETAIL_ZERO   = 8'hB3;
    localparam logic [7:0]  OFS_CONFIG_BASE           = 8'hB7;
    localparam logic [7:0]  OFS_CONFIG_WRITE_LOCK     = 8'hBF;
    localparam logic [7:0]  OFS_SAFE_LDO_CONTROL      = 8'hC6;
    localparam int          DETAIL_COUNT              = 4;
    localparam int          CONFIG_COUNT              = 8;
    localparam logic [7:0]  PROTECTED_CONFIG          = 8'hBE;
    localparam logic [7:0]  RST_SYSTEM_EVENT_MASK     = 8'hFF;
    localparam logic [7:0]  RST_CHARGER_EVENT_FLAGS   = 8'h00;
    localparam logic [7:0]  RST_CHARGER_EVENT_MASK    = 8'hFF;
    localparam logic [7:0]  RST_CHARGER_OKAY_STATUS   = 8'h00;
    localparam logic [7:0]  RST_SAFE_LDO_CONTROL      = 8'h75;
    localparam logic [7:0]  RST_CONFIG                = 8'h00;
    localparam logic [7:0]  RST_CONFIG_WRITE_LOCK     = 8'h00;
    localparam int          BIT_LOW_SUPPLY_MASK       = 3;
    localparam int          BIT_DIE_HOT_HIGH_MASK     = 1;
    localparam int          BIT_DIE_HOT_LOW_MASK      = 0;
    localparam int          BIT_INTERNAL_REG_EN       = 7;
    localparam int          BIT_PROTECTED_OUT_EN      = 6;
    localparam int          BIT_PROTECTED_DISCHARGE   = 4;
    localparam int          VSEL_LSB                  = 0;
    localparam int          VSEL_W                    = 2;
    localparam logic [1:0]  VSEL_4V85                 = 2'h0;
    localparam logic [1:0]  VSEL_4V90                 = 2'h1;
    localparam logic [1:0]  VSEL_4V95                 = 2'h2;
    localparam logic [1:0]  VSEL_3V30                 = 2'h3;
    localparam int          BIT_BYPASS_NODE           = 0;
    localparam int          BIT_BATTERY_OVERCURRENT   = 1;
    localparam int          BIT_BATTERY_PRESENCE      = 2;
    localparam int          BIT_SUMMARY_CHARGER       = 0;
    localparam int          BIT_WRITE_LOCK            = 0;
    localparam logic [3:0]  LINK_BYTE_BITS            = 4'h8;

    typedef enum logic [3:0] {
        LINK_IDLE, LINK_ADDR, LINK_ACK_ADDR, LINK_REG, LINK_ACK_WRITE,
        LINK_WRITE, LINK_READ, LINK_ACK_READ
    } link_state_t;
endpackage

// file: src/reg_bus_if.sv
interface reg_bus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
    logic [7:0] rdata;
    modport ctrl (output addr, output wdata, output we, output re, input rdata);
    modport regs (input addr, input wdata, input we, input re, output rdata);
endinterface

// file: src/serial_target.sv
module serial_target #(
    parameter logic [6:0] DEVICE_ADDRESS = 7'h2A  // arbitrary value
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_oe,
    reg_bus_if.ctrl   bus
);
    charger_regs_pkg::link_state_t st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] ptr, next_ptr;
    logic       rw, next_rw;
    logic       nack, next_nack;
    logic       next_oe;
    logic       scl_q, sda_q;
    logic       load, wr;
    logic       scl_rise, scl_fall, start_cond, stop_cond;

    assign scl_rise   = scl_in & ~scl_q;
    assign scl_fall   = ~scl_in & scl_q;
    assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;

    assign bus.addr  = ptr;
    assign bus.wdata = shift;
    assign bus.we    = wr & ce;
    // the read strobe fires when a byte is fetched, so clear-on-read happens once per byte
    assign bus.re    = load & ce;

    always_comb begin
        next_st    = st;
        next_cnt   = cnt;
        next_shift = shift;
        next_ptr   = ptr;
        next_rw    = rw;
        next_nack  = nack;
        next_oe    = sda_oe;
        load       = 1'b0;
        wr         = 1'b0;
        if (start_cond) begin
            next_st  = charger_regs_pkg::LINK_ADDR;
            next_cnt = 4'h0;
            next_oe  = 1'b0;
        end else if (stop_cond) begin
            next_st = charger_regs_pkg::LINK_IDLE;
            next_oe = 1'b0;
        end else if (scl_rise) begin
            if (cnt < charger_regs_pkg::LINK_BYTE_BITS) begin
                next_cnt = cnt + 4'h1;
                if (st inside {charger_regs_pkg::LINK_ADDR, charger_regs_pkg::LINK_REG,
                               charger_regs_pkg::LINK_WRITE}) begin
                    next_shift = {shift[6:0], sda_in};
                end
            end
            if (st == charger_regs_pkg::LINK_ACK_READ) begin
                next_nack = sda_in;
            end
        end else if (scl_fall) begin
            unique case (st)
                charger_regs_pkg::LINK_IDLE: begin
                end
                charger_regs_pkg::LINK_ADDR: begin
                    if (cnt == charger_regs_pkg::LINK_BYTE_BITS) begin
                        if (shift[7:1] == DEVICE_ADDRESS) begin
                            next_oe = 1'b1;
                            next_rw = shift[0];
                            next_st = charger_regs_pkg::LINK_ACK_ADDR;
                        end else begin
                            next_st = charger_regs_pkg::LINK_IDLE;
                        end
                    end
                end
                charger_regs_pkg::LINK_REG, charger_regs_pkg::LINK_WRITE: begin
                    if (cnt == charger_regs_pkg::LINK_BYTE_BITS) begin
                        next_oe = 1'b1;
                        next_st = charger_regs_pkg::LINK_ACK_WRITE;
                        if (st == charger_regs_pkg::LINK_REG) begin
                            next_ptr = shift;
                        end else begin
                            wr       = 1'b1;
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                charger_regs_pkg::LINK_ACK_ADDR: begin
                    if (rw) begin
                        load = 1'b1;
                    end else begin
                        next_oe  = 1'b0;
                        next_cnt = 4'h0;
                        next_st  = charger_regs_pkg::LINK_REG;
                    end
                end
                charger_regs_pkg::LINK_ACK_WRITE: begin
                    next_oe  = 1'b0;
                    next_cnt = 4'h0;
                    next_st  = charger_regs_pkg::LINK_WRITE;
                end
                charger_regs_pkg::LINK_READ: begin
                    if (cnt == charger_regs_pkg::LINK_BYTE_BITS) begin
                        next_oe = 1'b0;
                        next_st = charger_regs_pkg::LINK_ACK_READ;
                    end else begin
                        next_shift = {shift[6:0], 1'b0};
                        next_oe    = ~shift[6];
                    end
                end
                charger_regs_pkg::LINK_ACK_READ: begin
                    if (nack) begin
                        next_st = charger_regs_pkg::LINK_IDLE;
                    end else begin
                        load = 1'b1;
                    end
                end
                default: begin
                    next_st = charger_regs_pkg::LINK_IDLE;
                    next_oe = 1'b0;
                end
            endcase
        end
        if (load) begin
            next_shift = bus.rdata;
            next_oe    = ~bus.rdata[7];
            next_cnt   = 4'h0;
            next_ptr   = ptr + 8'h01;
            next_st    = charger_regs_pkg::LINK_READ;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st     <= charger_regs_pkg::LINK_IDLE;
            cnt    <= 4'h0;
            shift  <= 8'h00;
            ptr    <= 8'h00;
            rw     <= 1'b0;
            nack   <= 1'b0;
            sda_oe <= 1'b0;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end else if (ce) begin
            st     <= next_st;
            cnt    <= next_cnt;
            shift  <= next_shift;
            ptr    <= next_ptr;
            rw     <= next_rw;
            nack   <= next_nack;
            sda_oe <= next_oe;
            scl_q  <= scl_in;
            sda_q  <= sda_in;
        end
    end
endmodule

// file: src/charger_event_and_ldo_regs.sv
module charger_event_and_ldo_regs #(
    parameter logic [6:0] DEVICE_ADDRESS = 7'h2A  // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [7:0]  okay_in,
    input  wire logic [31:0] detail_in,
    output logic             irq_n,
    output logic             charger_summary_event,
    output logic             low_supply_event_mask,
    output logic             die_hot_high_event_mask,
    output logic             die_hot_low_event_mask,
    output logic             internal_regulator_enable,
    output logic             protected_output_enable,
    output logic             protected_output_discharge_enable,
    output logic [1:0]       protected_output_voltage_select,
    output logic [63:0]      config_settings,
    output logic             config_write_lock
);
    reg_bus_if bus ();

    logic [7:0] system_event_mask,   next_system_event_mask;
    logic [7:0] charger_event_flags, next_charger_event_flags;
    logic [7:0] charger_event_mask,  next_charger_event_mask;
    logic [7:0] charger_okay_status, next_charger_okay_status;
    logic [7:0] safe_ldo_control,    next_safe_ldo_control;
    logic [7:0] write_lock,          next_write_lock;
    logic [7:0] cfg      [charger_regs_pkg::CONFIG_COUNT];
    logic [7:0] next_cfg [charger_regs_pkg::CONFIG_COUNT];
    logic       next_irq_n;
    logic       next_summary;
    logic [7:0] okay_change;
    logic       flags_read;
    logic [7:0] rd;

    serial_target #(
        .DEVICE_ADDRESS (DEVICE_ADDRESS)
    ) u_link (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .sda_oe (sda_oe),
        .bus    (bus.ctrl)
    );

    // open-drain: the line is only ever pulled low
    assign sda_out = 1'b0;

    assign low_supply_event_mask   = system_event_mask[charger_regs_pkg::BIT_LOW_SUPPLY_MASK];
    assign die_hot_high_event_mask = system_event_mask[charger_regs_pkg::BIT_DIE_HOT_HIGH_MASK];
    assign die_hot_low_event_mask  = system_event_mask[charger_regs_pkg::BIT_DIE_HOT_LOW_MASK];
    assign internal_regulator_enable =
        safe_ldo_control[charger_regs_pkg::BIT_INTERNAL_REG_EN];
    assign protected_output_enable =
        safe_ldo_control[charger_regs_pkg::BIT_PROTECTED_OUT_EN];
    assign protected_output_discharge_enable =
        safe_ldo_control[charger_regs_pkg::BIT_PROTECTED_DISCHARGE];
    assign protected_output_voltage_select =
        safe_ldo_control[charger_regs_pkg::VSEL_LSB +: charger_regs_pkg::VSEL_W];
    assign config_write_lock = write_lock[charger_regs_pkg::BIT_WRITE_LOCK];

    for (genvar g = 0; g < charger_regs_pkg::CONFIG_COUNT; g++) begin : g_cfg_out
        assign config_settings[g*8 +: 8] = cfg[g];
    end

    // read mux; detail registers pass the analog side's words straight through
    always_comb begin
        rd = 8'h00;
        unique case (bus.addr)
            charger_regs_pkg::OFS_EVENT_SUMMARY: begin
                rd[charger_regs_pkg::BIT_SUMMARY_CHARGER] = charger_summary_event;
            end
            charger_regs_pkg::OFS_SYSTEM_EVENT_MASK:   rd = system_event_mask;
            charger_regs_pkg::OFS_CHARGER_EVENT_FLAGS: rd = charger_event_flags;
            charger_regs_pkg::OFS_CHARGER_EVENT_MASK:  rd = charger_event_mask;
            charger_regs_pkg::OFS_CHARGER_OKAY_STATUS: rd = charger_okay_status;
            charger_regs_pkg::OFS_CONFIG_WRITE_LOCK:   rd = write_lock;
            charger_regs_pkg::OFS_SAFE_LDO_CONTROL:    rd = safe_ldo_control;
            default: begin
                for (int i = 0; i < charger_regs_pkg::DETAIL_COUNT; i++) begin
                    if (bus.addr == 8'(charger_regs_pkg::OFS_CHARGER_DETAIL_ZERO + i)) begin
                        rd = detail_in[i*8 +: 8];
                    end
                end
                for (int i = 0; i < charger_regs_pkg::CONFIG_COUNT; i++) begin
                    if (bus.addr == 8'(charger_regs_pkg::OFS_CONFIG_BASE + i)) begin
                        rd = cfg[i];
                    end
                end
            end
        endcase
    end
    assign bus.rdata = rd;

    always_comb begin
        next_system_event_mask = system_event_mask;
        next_charger_event_mask = charger_event_mask;
        next_safe_ldo_control = safe_ldo_control;
        next_write_lock = write_lock;
        if (bus.we) begin
            if (bus.addr == charger_regs_pkg::OFS_SYSTEM_EVENT_MASK) begin
                next_system_event_mask = bus.wdata;
            end
            if (bus.addr == charger_regs_pkg::OFS_CHARGER_EVENT_MASK) begin
                next_charger_event_mask = bus.wdata;
            end
            if (bus.addr == charger_regs_pkg::OFS_SAFE_LDO_CONTROL) begin
                next_safe_ldo_control = bus.wdata;
            end
            if (bus.addr == charger_regs_pkg::OFS_CONFIG_WRITE_LOCK) begin
                next_write_lock = bus.wdata;
            end
        end
        for (int i = 0; i < charger_regs_pkg::CONFIG_COUNT; i++) begin
            next_cfg[i] = cfg[i];
            if (bus.we && bus.addr == 8'(charger_regs_pkg::OFS_CONFIG_BASE + i)
                && !(write_lock[charger_regs_pkg::BIT_WRITE_LOCK]
                     && charger_regs_pkg::PROTECTED_CONFIG[i])) begin
                next_cfg[i] = bus.wdata;
            end
        end
    end

    // the okay byte is registered once; its change against the registered copy is the event
    always_comb begin
        next_charger_okay_status = okay_in;
        okay_change = okay_in ^ charger_okay_status;
        flags_read = bus.re && bus.addr == charger_regs_pkg::OFS_CHARGER_EVENT_FLAGS;
        // the change term is or-ed in after the clear, so a same-cycle event survives
        next_charger_event_flags =
            (flags_read ? 8'h00 : charger_event_flags) | okay_change;
        next_summary = |next_charger_event_flags;
        next_irq_n = ~|(next_charger_event_flags & ~next_charger_event_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_event_mask     <= charger_regs_pkg::RST_SYSTEM_EVENT_MASK;
            charger_event_flags   <= charger_regs_pkg::RST_CHARGER_EVENT_FLAGS;
            charger_event_mask    <= charger_regs_pkg::RST_CHARGER_EVENT_MASK;
            charger_okay_status   <= charger_regs_pkg::RST_CHARGER_OKAY_STATUS;
            safe_ldo_control      <= charger_regs_pkg::RST_SAFE_LDO_CONTROL;
            write_lock            <= charger_regs_pkg::RST_CONFIG_WRITE_LOCK;
            irq_n                 <= 1'b1;
            charger_summary_event <= 1'b0;
            for (int i = 0; i < charger_regs_pkg::CONFIG_COUNT; i++) begin
                cfg[i] <= charger_regs_pkg::RST_CONFIG;
            end
        end else if (ce) begin
            system_event_mask     <= next_system_event_mask;
            charger_event_flags   <= next_charger_event_flags;
            charger_event_mask    <= next_charger_event_mask;
            charger_okay_status   <= next_charger_okay_status;
            safe_ldo_control      <= next_safe_ldo_control;
            write_lock            <= next_write_lock;
            irq_n                 <= next_irq_n;
            charger_summary_event <= next_summary;
            for (int i = 0; i < charger_regs_pkg::CONFIG_COUNT; i++) begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_flags_read;
        ce && bus.re && bus.addr == charger_regs_pkg::OFS_CHARGER_EVENT_FLAGS;
    endsequence

    sequence s_okay_quiet;
        (okay_in ^ charger_okay_status) == 8'h00;
    endsequence

    a_bypass_flag_set: assert property (
        ce && okay_in[0] != charger_okay_status[0] |=> charger_event_flags[0])
        else $error("bypass change did not set its flag");

    a_presence_flag_held: assert property (
        ce && charger_event_flags[2] && !bus.re |=> charger_event_flags[2])
        else $error("presence flag lost without a read");

    a_read_clears_flags: assert property (
        s_flags_read ##0 s_okay_quiet |=> charger_event_flags == 8'h00 && !charger_summary_event)
        else $error("clearing read left flags set");

    a_set_beats_clear: assert property (
        s_flags_read ##0 (okay_in[1] != charger_okay_status[1]) |=> charger_event_flags[1])
        else $error("overcurrent event lost during clearing read");

    a_irq_gated_mask: assert property (
        irq_n == !(|(charger_event_flags & ~charger_event_mask)))
        else $error("interrupt pin disagrees with unmasked flags");

    a_summary_tracks_flags: assert property (
        charger_summary_event == (|charger_event_flags))
        else $error("summary bit disagrees with pending flags");

    a_locked_cfg_kept: assert property (
        ce && bus.we && config_write_lock
        && bus.addr == 8'(charger_regs_pkg::OFS_CONFIG_BASE + 1) |=> $stable(cfg[1]))
        else $error("locked config entry changed");

    a_ldo_write_taken: assert property (
        ce && bus.we && bus.addr == charger_regs_pkg::OFS_SAFE_LDO_CONTROL
        |=> safe_ldo_control == $past(bus.wdata))
        else $error("regulator control write not taken");

    a_low_supply_mask: assert property (
        ce && bus.we && bus.addr == charger_regs_pkg::OFS_SYSTEM_EVENT_MASK
        |=> low_supply_event_mask == $past(bus.wdata[3]))
        else $error("low supply mask write not taken");

    a_status_mirror: assert property (
        ce |=> charger_okay_status == $past(okay_in))
        else $error("status register does not follow okay inputs");
endmodule

// file: sim/serial_host_model.sv
module serial_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] dev = 7'h2A;  // arbitrary value, matches the device default
    int         nacks = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // sda only moves while scl is low, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        tick(2);
        scl = 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic start();
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic xfer(input logic [7:0] v, input logic ack_in, output logic [7:0] r);
        logic k;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
        bit_io(ack_in, k);
        nacks += int'(k);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({dev, 1'b0}, 1'b1, r);
        xfer(a, 1'b1, r);
        xfer(d, 1'b1, r);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b0;
        tick(2);
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({dev, 1'b0}, 1'b1, r);
        xfer(a, 1'b1, r);
        start();
        xfer({dev, 1'b1}, 1'b1, r);
        // one-bit nack pattern from the host ends the read; the device releases sda
        xfer(8'hFF, 1'b1, d);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_low = 1'b0;
        tick(2);
    endtask
endmodule

// file: sim/test_charger_event_and_ldo_regs.sv
module test_charger_event_and_ldo_regs;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] okay_in = 8'h00;
    logic [31:0] detail_in = 32'h4433_2211;
    logic scl, host_low, sda_oe, irq_n, charger_summary_event, config_write_lock;
    logic ls, hh, hl, ire, poe, pde;
    logic [1:0] vsel;
    logic [63:0] config_settings;
    int err_total = 0, checks_done = 0, n;
    wire sda_line = !(host_low | sda_oe);
    row_t rows[8] = '{'{1'b0, 8'h26, 8'h00, 8'hFF}, '{1'b0, 8'hC6, 8'h00, 8'h75},
        '{1'b0, 8'hB0, 8'h00, 8'h00}, '{1'b0, 8'hB1, 8'h00, 8'hFF},
        '{1'b1, 8'h26, 8'h00, 8'h00}, '{1'b1, 8'hC6, 8'h8A, 8'h8A},
        '{1'b1, 8'hC6, 8'h43, 8'h43}, '{1'b1, 8'hB1, 8'hF8, 8'hF8}};
    charger_event_and_ldo_regs charger_event_and_ldo_regs_inst (.clk, .rst, .ce(1'b1),
        .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe, .okay_in, .detail_in, .irq_n,
        .charger_summary_event, .low_supply_event_mask(ls), .die_hot_high_event_mask(hh),
        .die_hot_low_event_mask(hl), .internal_regulator_enable(ire),
        .protected_output_enable(poe), .protected_output_discharge_enable(pde),
        .protected_output_voltage_select(vsel), .config_settings, .config_write_lock);
    serial_host_model serial_host_model_inst (.clk, .sda(sda_line), .scl, .sda_low(host_low));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        serial_host_model_inst.write_reg(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        serial_host_model_inst.read_reg(a, d);
        chk(d, e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({ire, poe, pde, vsel, ls, hh, hl}, 8'h6F);
        chk_bit(irq_n, 1'b1);
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
            if (rows[i].a == 8'hC6) chk({ire, poe, pde, vsel}, {rows[i].e[7:6], rows[i].e[4], rows[i].e[1:0]});
            if (rows[i].a == 8'h26) chk({ls, hh, hl}, {rows[i].e[3], rows[i].e[1:0]});
        end
        $display("test register rows done");
        okay_in = 8'h05;
        repeat (3) @(negedge clk);
        chk_bit(irq_n, 1'b0);
        chk_bit(charger_summary_event, 1'b1);
        rd(8'hB2, 8'h05);
        rd(8'h22, 8'h01);
        rd(8'hB0, 8'h05);
        rd(8'hB0, 8'h00);
        chk({irq_n, charger_summary_event}, 8'h02);
        wr(8'hB1, 8'hFF);
        okay_in = 8'h07;
        repeat (3) @(negedge clk);
        chk({irq_n, charger_summary_event}, 8'h03);
        rd(8'hB0, 8'h02);
        fork
            rd(8'hB0, 8'h00);
            begin
                // the fetch of this read lands 230 falling edges in; the event hits that edge
                repeat (230) @(negedge clk);
                okay_in = 8'h05;
            end
        join
        rd(8'hB0, 8'h02);
        $display("test events done");
        wr(8'hBF, 8'h01);
        chk_bit(config_write_lock, 1'b1);
        wr(8'hB8, 8'h5A);
        rd(8'hB8, 8'h00);
        wr(8'hB7, 8'h33);
        rd(8'hB7, 8'h33);
        chk(config_settings[15:8], 8'h00);
        wr(8'hBF, 8'h00);
        wr(8'hB8, 8'h5A);
        rd(8'hB8, 8'h5A);
        rd(8'hB3, 8'h11);
        rd(8'hB6, 8'h44);
        $display("test lock and detail done");
        n = serial_host_model_inst.nacks;
        serial_host_model_inst.dev = 7'h11;
        wr(8'h26, 8'hFF);
        serial_host_model_inst.dev = 7'h2A;
        chk(8'(serial_host_model_inst.nacks - n), 8'h03);
        rd(8'h26, 8'h00);
        okay_in = 8'h00;
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({irq_n, charger_summary_event}, 8'h02);
        rd(8'hC6, 8'h75);
        rd(8'hB0, 8'h00);
        $display("test address and reset done");
        report_and_stop();
    end
endmodule
